//--- pkg/iprc_pkg.sv
// Purpose: constants for interrupt priority and reset cause block
// Assumes: 8-bit register port, one clock domain
// Notes  : offsets below are local register indices
// Functional notes
// - eight priority bits, one high, reset ones
// - reset cause flags readable by software
// - flags show wake from idle or sleep
// - bit 7 enables two priority levels
// - cause flag layout, access and reset values
// - priority bits ignored while levels disabled
`default_nettype none
package iprc_pkg;
	// ----------------------------------------
	// bus geometry
	// ----------------------------------------
	localparam int DW = 8;
	localparam int AW = 2;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [AW-1:0] OFS_PRIO   = 2'h0;
	localparam logic [AW-1:0] OFS_RCAUSE = 2'h1;
	localparam logic [AW-1:0] OFS_IRQ_ST = 2'h2;
	localparam logic [AW-1:0] OFS_IRQ_MK = 2'h3;
	// ----------------------------------------
	// reset cause control fields
	// ----------------------------------------
	localparam int B_PLEN = 7;
	localparam int B_RSTI  = 4;
	localparam int B_WDTO  = 3;
	localparam int B_PWDN  = 2;
	localparam int B_POR   = 1;
	localparam int B_BROWN = 0;
	localparam logic [DW-1:0] RCAUSE_IMPL = 8'h9F;
	localparam logic [DW-1:0] RCAUSE_SWWR = 8'h93;
	localparam logic [DW-1:0] RCAUSE_RST  = 8'h1C;
	localparam logic [DW-1:0] PRIO_RST    = 8'hFF;
	localparam logic [DW-1:0] ALL_HIGH    = 8'hFF;
	// ----------------------------------------
	// event status fields
	// ----------------------------------------
	localparam int EV_N     = 5;
	localparam int E_RSTI   = 0;
	localparam int E_WDTO   = 1;
	localparam int E_BROWN  = 2;
	localparam int E_WSLEEP = 3;
	localparam int E_WIDLE  = 4;
	localparam logic [DW-1:0] IRQ_RST = 8'h00;
endpackage
`default_nettype wire

//--- rtl/iprc_top.sv
// Purpose: priority register and reset cause register with event irq
// Assumes: inputs synchronous to REF_CLK_IN, event inputs one-cycle pulses
// Notes  : read data appears the cycle after the read strobe only
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module iprc_top
(
	// clock and reset
	input  wire logic                     REF_CLK_IN,
	input  wire logic                     SYS_RST_IN,
	// register port
	input  wire logic [iprc_pkg::AW-1:0]  REG_ADDR_IN,
	input  wire logic [iprc_pkg::DW-1:0]  REG_WDATA_IN,
	input  wire logic                     REG_WR_IN,
	input  wire logic                     REG_RD_IN,
	output logic      [iprc_pkg::DW-1:0]  REG_RDATA_OUT,
	// core events
	input  wire logic                     RESET_INSTR_IN,
	input  wire logic                     WDT_TIMEOUT_IN,
	input  wire logic                     WDT_CLEAR_IN,
	input  wire logic                     BROWN_OUT_IN,
	input  wire logic                     IDLE_WAKE_IN,
	input  wire logic                     SLEEP_WAKE_IN,
	// priority view for the vectoring logic
	output logic      [iprc_pkg::DW-1:0]  EFF_PRIO_OUT,
	output logic                          PRIO_LEVELS_OUT,
	// interrupt
	output logic                          IRQ_OUT
);
	import iprc_pkg::*;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic          wr_prio;
	logic          wr_rcause;
	logic          wr_st;
	logic          wr_mk;
	logic [DW-1:0] prio_ff;
	logic [DW-1:0] rcause_ff;
	logic [DW-1:0] nxt_rcause;
	logic [DW-1:0] irq_st_ff;
	logic [DW-1:0] irq_mk_ff;
	logic [DW-1:0] nxt_irq_st;
	logic [DW-1:0] ev_vec;
	logic [DW-1:0] rd_mux;

	assign wr_prio   = REG_WR_IN && (REG_ADDR_IN == OFS_PRIO);
	assign wr_rcause = REG_WR_IN && (REG_ADDR_IN == OFS_RCAUSE);
	assign wr_st     = REG_WR_IN && (REG_ADDR_IN == OFS_IRQ_ST);
	assign wr_mk     = REG_WR_IN && (REG_ADDR_IN == OFS_IRQ_MK);

	// ----------------------------------------
	// peripheral priority three
	// ----------------------------------------
	always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			prio_ff <= PRIO_RST;
		else if (wr_prio)
			prio_ff <= REG_WDATA_IN;
	end

	// ----------------------------------------
	// reset cause control
	// ----------------------------------------
	// hardware events are applied after the software write so they win
	always_comb
	begin
		nxt_rcause = rcause_ff;
		if (wr_rcause)
			nxt_rcause = (rcause_ff & ~RCAUSE_SWWR) | (REG_WDATA_IN & RCAUSE_SWWR);
		if (RESET_INSTR_IN)
			nxt_rcause[B_RSTI] = 1'b0;
		if (BROWN_OUT_IN)
			nxt_rcause[B_BROWN] = 1'b0;
		if (WDT_CLEAR_IN)
		begin
			nxt_rcause[B_WDTO] = 1'b1;
			nxt_rcause[B_PWDN] = 1'b1;
		end
		if (WDT_TIMEOUT_IN)
			nxt_rcause[B_WDTO] = 1'b0;
		// sleep wake leaves power-down low, idle wake raises it
		if (SLEEP_WAKE_IN)
			nxt_rcause[B_PWDN] = 1'b0;
		else if (IDLE_WAKE_IN)
			nxt_rcause[B_PWDN] = 1'b1;
		nxt_rcause = nxt_rcause & RCAUSE_IMPL;
	end

	always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			rcause_ff <= RCAUSE_RST;
		else
			rcause_ff <= nxt_rcause;
	end

	// ----------------------------------------
	// effective priority
	// ----------------------------------------
	// single-level mode routes every source to one level
	always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
		begin
			EFF_PRIO_OUT    <= ALL_HIGH;
			PRIO_LEVELS_OUT <= 1'b0;
		end
		else
		begin
			EFF_PRIO_OUT    <= nxt_rcause[B_PLEN] ? nxt_prio() : ALL_HIGH;
			PRIO_LEVELS_OUT <= nxt_rcause[B_PLEN];
		end
	end

	function automatic logic [DW-1:0] nxt_prio();
		return wr_prio ? REG_WDATA_IN : prio_ff;
	endfunction

	// ----------------------------------------
	// event status and mask
	// ----------------------------------------
	assign ev_vec = {3'h0, IDLE_WAKE_IN, SLEEP_WAKE_IN, BROWN_OUT_IN, WDT_TIMEOUT_IN, RESET_INSTR_IN};

	always_comb
	begin
		nxt_irq_st = irq_st_ff;
		if (wr_st)
			nxt_irq_st = nxt_irq_st & ~REG_WDATA_IN;
		// a new event in the clearing cycle is kept
		nxt_irq_st = nxt_irq_st | ev_vec;
	end

	always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			irq_st_ff <= IRQ_RST;
		else
			irq_st_ff <= nxt_irq_st;
	end

	always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			irq_mk_ff <= IRQ_RST;
		else if (wr_mk)
			irq_mk_ff <= {3'h0, REG_WDATA_IN[EV_N-1:0]};
	end

	always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			IRQ_OUT <= 1'b0;
		else
			IRQ_OUT <= |(nxt_irq_st & (wr_mk ? {3'h0, REG_WDATA_IN[EV_N-1:0]} : irq_mk_ff));
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	always_comb
	begin
		case (REG_ADDR_IN)
			OFS_PRIO:   rd_mux = prio_ff;
			OFS_RCAUSE: rd_mux = rcause_ff & RCAUSE_IMPL;
			OFS_IRQ_ST: rd_mux = irq_st_ff;
			OFS_IRQ_MK: rd_mux = irq_mk_ff;
			default:    rd_mux = 8'h00;
		endcase
	end

	// data stands only in the cycle after the strobe
	always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			REG_RDATA_OUT <= 8'h00;
		else if (REG_RD_IN)
			REG_RDATA_OUT <= rd_mux;
		else
			REG_RDATA_OUT <= 8'h00;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_prio_write;
		wr_prio && !REG_RD_IN;
	endsequence

	sequence s_prio_read;
		REG_RD_IN && (REG_ADDR_IN == OFS_PRIO);
	endsequence

	a_prio_write_read: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		s_prio_write ##1 (s_prio_read and !wr_prio) |=> REG_RDATA_OUT == $past(REG_WDATA_IN, 2))
		else $error("priority readback differs from write");

	a_ri_cleared: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		RESET_INSTR_IN |=> !rcause_ff[B_RSTI])
		else $error("reset instruction flag not cleared");

	a_sleep_wake_pd: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		SLEEP_WAKE_IN |=> !rcause_ff[B_PWDN] && irq_st_ff[E_WSLEEP])
		else $error("sleep wake not recorded");

	a_levels_follow: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		wr_rcause |=> PRIO_LEVELS_OUT == $past(REG_WDATA_IN[B_PLEN]))
		else $error("priority level enable not applied");

	a_ro_flags_kept: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		wr_rcause && !WDT_TIMEOUT_IN && !WDT_CLEAR_IN && !SLEEP_WAKE_IN && !IDLE_WAKE_IN
		|=> rcause_ff[B_WDTO:B_PWDN] == $past(rcause_ff[B_WDTO:B_PWDN]))
		else $error("read-only cause flags changed by write");

	a_single_level: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		!PRIO_LEVELS_OUT |-> EFF_PRIO_OUT == ALL_HIGH)
		else $error("priority bits used in single-level mode");

	a_eff_prio_track: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		PRIO_LEVELS_OUT |-> EFF_PRIO_OUT == prio_ff)
		else $error("effective priority lost");

	a_gap_bits_zero: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		REG_RD_IN && (REG_ADDR_IN == OFS_RCAUSE) |=> REG_RDATA_OUT[6:5] == 2'b00)
		else $error("unimplemented cause bits read nonzero");

	a_irq_level: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		IRQ_OUT == |(irq_st_ff & irq_mk_ff))
		else $error("interrupt level disagrees with status and mask");

	// ----------------------------------------
	// priority, cause, status and read path checks
	// ----------------------------------------
	// a same-cycle reset instruction or brown-out event may override the written RSTI or BROWN bit
	sequence s_cause_write;
		wr_rcause && !RESET_INSTR_IN && !BROWN_OUT_IN;
	endsequence

	sequence s_no_wake_or_dog;
		!WDT_TIMEOUT_IN && !WDT_CLEAR_IN && !SLEEP_WAKE_IN && !IDLE_WAKE_IN;
	endsequence

	sequence s_cause_read;
		REG_RD_IN && (REG_ADDR_IN == OFS_RCAUSE);
	endsequence

	a_prio_reset_ones: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		$fell(SYS_RST_IN) |-> prio_ff == PRIO_RST)
		else $error("priority register not all ones after reset");

	a_cause_reset_value: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		$fell(SYS_RST_IN) |-> rcause_ff == RCAUSE_RST)
		else $error("cause register reset value wrong");

	a_prio_hold: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		!wr_prio |=> $stable(prio_ff))
		else $error("priority register changed without a write");

	a_brown_out_clear: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		BROWN_OUT_IN |=> !rcause_ff[B_BROWN] && irq_st_ff[E_BROWN])
		else $error("brown-out not recorded");

	a_timeout_clear: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		WDT_TIMEOUT_IN |=> !rcause_ff[B_WDTO] && irq_st_ff[E_WDTO])
		else $error("watchdog timeout not recorded");

	a_idle_wake_pd: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		IDLE_WAKE_IN && !SLEEP_WAKE_IN |=> rcause_ff[B_PWDN] && irq_st_ff[E_WIDLE])
		else $error("idle wake not recorded");

	a_dog_clear_flags: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		WDT_CLEAR_IN && !WDT_TIMEOUT_IN && !SLEEP_WAKE_IN |=> rcause_ff[B_WDTO] && rcause_ff[B_PWDN])
		else $error("watchdog clear did not raise flags");

	a_sw_cause_write: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		(s_cause_write and s_no_wake_or_dog) |=> (rcause_ff & RCAUSE_SWWR) == ($past(REG_WDATA_IN) & RCAUSE_SWWR))
		else $error("writable cause bits not taken");

	a_gap_bits_held: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		rcause_ff[6:5] == 2'b00)
		else $error("unimplemented cause bits stored");

	a_cause_readback: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		s_cause_read |=> REG_RDATA_OUT == $past(rcause_ff))
		else $error("cause readback differs from register");

	a_rdata_idle: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		!REG_RD_IN |=> REG_RDATA_OUT == 8'h00)
		else $error("read data not zero outside a read");

	a_event_beats_clear: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		wr_st && (|ev_vec) |=> (irq_st_ff & $past(ev_vec)) == $past(ev_vec))
		else $error("event lost under a status clear");

	a_status_w1c: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
		wr_st && !(|ev_vec) |=> irq_st_ff == ($past(irq_st_ff) & ~$past(REG_WDATA_IN)))
		else $error("status write-one-to-clear wrong");

endmodule
`default_nettype wire

//--- test/iprc_top_test.sv
// Purpose: self-checking bench for the priority and reset cause registers
// Assumes: read data one cycle after the strobe, events as one-cycle pulses
// Notes  : driver queues expected reads, a negedge monitor compares them
`timescale 1ns/1ps
`default_nettype none
module iprc_top_test;
	import iprc_pkg::*;
	// ----------------------------------------
	// stimulus and observation
	// ----------------------------------------
	logic          clk      = 1'b0;
	logic          rst      = 1'b1;
	logic [AW-1:0] addr     = '0;
	logic [DW-1:0] wdata    = '0;
	logic          reg_wr   = 1'b0;
	logic          reg_rd   = 1'b0;
	logic          rd_q     = 1'b0;
	logic [5:0]    evt      = '0;
	logic [DW-1:0] rdata;
	logic [DW-1:0] eff_prio;
	logic          levels;
	logic          irq;
	logic [DW-1:0] exp_q[$];
	logic [DW-1:0] prio, rc, st, mk, r;
	int            fails    = 0;
	int            n_checks = 0;
	int            cyc      = 0;
	always #4 clk = ~clk;
	iprc_top iprc_top_i (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
		.REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd), .REG_RDATA_OUT(rdata), .RESET_INSTR_IN(evt[0]),
		.WDT_TIMEOUT_IN(evt[1]), .BROWN_OUT_IN(evt[2]), .SLEEP_WAKE_IN(evt[3]), .IDLE_WAKE_IN(evt[4]),
		.WDT_CLEAR_IN(evt[5]), .EFF_PRIO_OUT(eff_prio), .PRIO_LEVELS_OUT(levels), .IRQ_OUT(irq));
	// ----------------------------------------
	// compare and closing
	// ----------------------------------------
	task automatic chk(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// bus, events and output view
	// ----------------------------------------
	task automatic bus_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		addr   <= a;
		wdata  <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic bus_rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
		exp_q.push_back(e);
		addr   <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic chk_outs();
		chk("effective priority", rc[B_PLEN] ? prio : ALL_HIGH, eff_prio);
		chk("priority levels", {7'h00, rc[B_PLEN]}, {7'h00, levels});
		chk("irq", {7'h00, |(st & mk)}, {7'h00, irq});
	endtask
	// pulse one event; status bit i follows event i, the last event has none
	task automatic ev(input int i);
		evt <= 6'(1 << i);
		@(posedge clk);
		evt <= '0;
		@(posedge clk);
		rc[B_RSTI]  = (i == 0) ? 1'b0 : rc[B_RSTI];
		rc[B_WDTO]  = (i == 1) ? 1'b0 : (i == 5) ? 1'b1 : rc[B_WDTO];
		rc[B_PWDN]  = (i == 3) ? 1'b0 : (i == 4 || i == 5) ? 1'b1 : rc[B_PWDN];
		rc[B_BROWN] = (i == 2) ? 1'b0 : rc[B_BROWN];
		if (i < EV_N)
			st[i] = 1'b1;
		chk_outs();
		bus_rd(OFS_RCAUSE, rc);
		bus_rd(OFS_IRQ_ST, st);
	endtask
	// ----------------------------------------
	// monitor and watchdog
	// ----------------------------------------
	always @(posedge clk)
		rd_q <= reg_rd;
	// read data stands one cycle only, zero otherwise
	always @(negedge clk)
		if (rd_q)
			chk("read data", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, rdata);
		else
			chk("idle read data", 8'h00, rdata);
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fails++;
			end_sim();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(71846));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		prio = PRIO_RST;
		rc   = RCAUSE_RST;
		st   = IRQ_RST;
		mk   = IRQ_RST;
		chk_outs();
		bus_rd(OFS_PRIO, prio);
		bus_rd(OFS_RCAUSE, rc);
		// read-only and unimplemented cause bits must survive any write
		repeat (10)
		begin
			prio = 8'($urandom);
			bus_wr(OFS_PRIO, prio);
			bus_rd(OFS_PRIO, prio);
			r = 8'($urandom);
			bus_wr(OFS_RCAUSE, r);
			rc = (rc & ~RCAUSE_SWWR) | (r & RCAUSE_SWWR);
			bus_rd(OFS_RCAUSE, rc);
			chk_outs();
		end
		for (int i = 0; i < 6; i++)
			ev(i);
		bus_wr(OFS_IRQ_MK, ALL_HIGH);
		mk = 8'h1F;
		bus_rd(OFS_IRQ_MK, mk);
		chk_outs();
		repeat (16)
		begin
			ev($urandom_range(5));
			r = 8'($urandom);
			bus_wr(OFS_IRQ_ST, r);
			st = st & ~r;
			r = 8'($urandom);
			bus_wr(OFS_IRQ_MK, r);
			mk = r & 8'h1F;
			chk_outs();
			bus_rd(OFS_IRQ_ST, st);
		end
		end_sim();
	end
endmodule
`default_nettype wire
